// *** src/adc_cmd_map.svh ***
// Opcodes, register positions, reset values and timing counts
`ifndef ADC_CMD_MAP_SVH
`define ADC_CMD_MAP_SVH

// Opcodes compared on bits 7:1 (bit 0 is don't care)
`define OPC7_WAKE   7'h00
`define OPC7_SLEEP  7'h01
`define OPC7_SYNC   7'h02
`define OPC7_RESET  7'h03
`define OPC7_FETCH  7'h09
`define OPC7_AUTO   7'h0a
`define OPC7_HALT   7'h0b
// Opcodes compared on bits 7:4
`define OPC4_REG_FETCH_CMD   4'h2
`define OPC4_REG_STORE_CMD   4'h4
// Full-byte opcodes
`define OPC_EXT_ZERO 8'h60
`define OPC_EXT_SPAN 8'h61
`define OPC_INT_ZERO 8'h62
`define OPC_FILLER   8'hff
`define OPC_RESERVED 8'hf1

// Register positions
`define REG_MUX0    4'h0
`define REG_REF     4'h2
`define REF_LSB     5
`define REF_MSB     6
`define REG_OFS0    4'h4
`define REG_GAIN0   4'h7
`define REG_IDAC1   4'hb

// Reset values
`define RST_MUX0    8'h01
`define RST_IDAC1   8'hff
`define RST_GAIN    8'h00
`define RST_OTHER   8'h00

// Timing
`define MCLK_NS      100
`define RST_HOLD_NS  600000
`define RST_HOLD_CYC ((`RST_HOLD_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// *** src/adc_cmd_pkg.sv ***
// Types shared by the command decoder
package adc_cmd_pkg;
  // Decoder states, one-hot
  typedef enum logic [5:0] {
    ST_OPC   = 6'b000001,
    ST_SYNC2 = 6'b000010,
    ST_RCNT  = 6'b000100,
    ST_RDATA = 6'b001000,
    ST_WCNT  = 6'b010000,
    ST_WDATA = 6'b100000
  } state_e;
  // Calibration kinds
  typedef enum logic [1:0] {
    CAL_NONE     = 2'h0,
    CAL_EXT_ZERO = 2'h1,
    CAL_EXT_SPAN = 2'h2,
    CAL_INT_ZERO = 2'h3
  } cal_e;
  typedef logic [7:0] byte_t;
endpackage : adc_cmd_pkg

// *** src/pin_sync.sv ***
// Two-flop synchroniser for pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int          W    = 3,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         arst_n,
  // Pins in, synced out
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= INIT;
      pinOut <= INIT;
    end else begin
      meta   <= pinIn;
      pinOut <= meta;
    end
  end
endmodule : pin_sync

// *** src/spi_byte_engine.sv ***
// Serial byte shifter: sample on falling SCLK, drive on rising
`timescale 1ns/1ps
module spi_byte_engine (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Synced pins
  input  wire logic        sclkS,
  input  wire logic        csNS,
  input  wire logic        dinS,
  // Transmit load
  input  wire logic        txLoad,
  input  wire logic [15:0] txData,
  // Receive side
  output logic       [7:0] rxByte,
  output logic             rxValid,
  output logic             rise8,
  output logic       [6:0] rxPartial,
  output logic             sclkRise,
  // Serial out
  output logic             dout
);
  logic        sclkPrev;
  logic        sclkFall;
  logic [2:0]  bitCnt;
  logic [7:0]  rxShift;
  logic [15:0] txShift;

  // Edge finding on the synced clock
  assign sclkRise  = sclkS & ~sclkPrev & ~csNS;
  assign sclkFall  = ~sclkS & sclkPrev & ~csNS;
  assign rxPartial = rxShift[6:0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) sclkPrev <= 1'b0;
    else         sclkPrev <= sclkS;
  end

  // Receive; chip select high drops a partial byte
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt  <= 3'h0;
      rxShift <= 8'h00;
      rxByte  <= 8'h00;
      rxValid <= 1'b0;
      rise8   <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      rise8   <= sclkRise && (bitCnt == 3'h7);
      if (csNS) begin
        bitCnt <= 3'h0;
      end else if (sclkFall) begin
        rxShift <= {rxShift[6:0], dinS};
        bitCnt  <= bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          rxByte  <= {rxShift[6:0], dinS};
          rxValid <= 1'b1;
        end
      end
    end
  end

  // Transmit, MSB first
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txShift <= 16'h0000;
      dout    <= 1'b0;
    end else if (txLoad) begin
      txShift <= txData;
    end else if (sclkRise) begin
      dout    <= txShift[15];
      txShift <= {txShift[14:0], 1'b0};
    end
  end
endmodule : spi_byte_engine

// *** src/adc_spi_command_decoder.sv ***
// Serial command decoder of the converter
`timescale 1ns/1ps
`include "adc_cmd_map.svh"

// What this block does
// - Wake opcode acts on eighth rising SCLK
// - Sleep waits for conversion end
// - Sleep leaves reference setting alone
// - Two sync bytes restart filter, conversion
// - Reset opcode restores registers, clears filter
// - Reset leaves serial interface; CS realigns
// - Reset holds registers for 0.6ms
// - Auto mode loads each result for readout
// - Whole-byte partial result reads allowed
// - Mode change applies at next ready
// - Halt stops auto loading after ready
// - Fetch copies latest result, any mode
// - Fetch accepted during last result byte
// - Register read returns n+1, wraps
// - Input ignored during register readout
// - Register write stores n+1 bytes
// - External zero trim updates offset trim
// - External span trim updates gain trim
// - Internal zero trim updates offset trim
module adc_spi_command_decoder #(
  parameter int RST_HOLD_CYC = `RST_HOLD_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Serial pins from the host
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              din,
  // Serial pins to the host
  output logic                   dout,
  output logic                   doutEn,
  output logic                   resultReadyN,
  // Converter core
  input  wire logic              convDone,
  input  wire logic [15:0]       convResult,
  output logic                   sleepMode,
  output logic                   refOn,
  output logic                   filterReset,
  output logic                   convRestart,
  output logic                   regsHeld,
  // Calibration engine
  output logic                   calStart,
  output adc_cmd_pkg::cal_e      calKind,
  input  wire logic              calDone,
  input  wire logic [23:0]       calCoef
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Match on the seven opcode bits
  function automatic logic op7(input logic [7:0] b, input logic [6:0] c);
    op7 = (b[7:1] == c);
  endfunction : op7

  // Power-up value of one register
  function automatic logic [7:0] rstVal(input logic [3:0] a);
    case (a)
      `REG_MUX0:                      rstVal = `RST_MUX0;
      `REG_IDAC1:                     rstVal = `RST_IDAC1;
      4'h7, 4'h8, 4'h9:               rstVal = `RST_GAIN;
      default:                        rstVal = `RST_OTHER;
    endcase
  endfunction : rstVal

  // ----------------------------------------
  // Pins and byte engine
  // ----------------------------------------

  logic [2:0]          pinS;
  logic [7:0]          rxByte;
  logic                rxValid;
  logic                rise8;
  logic [6:0]          rxPartial;
  logic                sclkRise;
  logic                txLoad;
  logic [15:0]         txData;
  logic                csNS;

  // Chip select idles high
  pin_sync #(.W(3), .INIT(3'b010)) uSync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pinIn  ({sclk, csN, din}),
    .pinOut (pinS)
  );

  assign csNS = pinS[1];

  // Byte shifting; CS high drops partial bytes
  spi_byte_engine uEng (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .sclkS     (pinS[2]),
    .csNS      (csNS),
    .dinS      (pinS[0]),
    .txLoad    (txLoad),
    .txData    (txData),
    .rxByte    (rxByte),
    .rxValid   (rxValid),
    .rise8     (rise8),
    .rxPartial (rxPartial),
    .sclkRise  (sclkRise),
    .dout      (dout)
  );

  // ----------------------------------------
  // Decoder state
  // ----------------------------------------

  adc_cmd_pkg::state_e state;
  logic [3:0]          addr;
  logic [3:0]          remain;
  logic [15:0]         holdCnt;
  logic [15:0]         lastResult;
  logic [7:0]          regs [16];
  logic                opcAccept;
  logic                rstHit;
  logic                syncHit;
  logic                autoLoad;
  logic                pendValid;
  logic                pendMode;
  logic                autoNext;
  logic                sleepPend;

  // A byte in opcode position, outside the reset hold
  assign opcAccept = rxValid && !csNS && (state == adc_cmd_pkg::ST_OPC)
                     && (holdCnt == 16'h0000);
  assign rstHit    = opcAccept && op7(rxByte, `OPC7_RESET);
  assign syncHit   = rxValid && !csNS && (state == adc_cmd_pkg::ST_SYNC2)
                     && op7(rxByte, `OPC7_SYNC);
  assign autoNext  = pendValid ? pendMode : autoLoad;

  // Command sequencing; CS high realigns the interface
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= adc_cmd_pkg::ST_OPC;
      addr   <= 4'h0;
      remain <= 4'h0;
    end else if (csNS) begin
      state <= adc_cmd_pkg::ST_OPC;
    end else if (rxValid) begin
      case (state)
        adc_cmd_pkg::ST_OPC: begin
          if (opcAccept && op7(rxByte, `OPC7_SYNC)) begin
            state <= adc_cmd_pkg::ST_SYNC2;
          end else if (opcAccept && rxByte[7:4] == `OPC4_REG_FETCH_CMD) begin
            addr  <= rxByte[3:0];
            state <= adc_cmd_pkg::ST_RCNT;
          end else if (opcAccept && rxByte[7:4] == `OPC4_REG_STORE_CMD) begin
            addr  <= rxByte[3:0];
            state <= adc_cmd_pkg::ST_WCNT;
          end
        end
        adc_cmd_pkg::ST_SYNC2: state <= adc_cmd_pkg::ST_OPC;
        adc_cmd_pkg::ST_RCNT: begin
          remain <= rxByte[3:0];
          state  <= adc_cmd_pkg::ST_RDATA;
        end
        adc_cmd_pkg::ST_RDATA: begin
          // Incoming bytes here are never decoded
          if (remain == 4'h0) begin
            state <= adc_cmd_pkg::ST_OPC;
          end else begin
            remain <= remain - 4'h1;
            addr   <= addr + 4'h1;
          end
        end
        adc_cmd_pkg::ST_WCNT: begin
          remain <= rxByte[3:0];
          state  <= adc_cmd_pkg::ST_WDATA;
        end
        adc_cmd_pkg::ST_WDATA: begin
          addr   <= addr + 4'h1;
          remain <= remain - 4'h1;
          if (remain == 4'h0) state <= adc_cmd_pkg::ST_OPC;
        end
        default: state <= adc_cmd_pkg::ST_OPC;
      endcase
    end
  end

  // ----------------------------------------
  // Output shift register loading
  // ----------------------------------------

  // Byte events first, then an automatic result load
  always_comb begin
    txLoad = 1'b0;
    txData = 16'h0000;
    if (rxValid && !csNS && state == adc_cmd_pkg::ST_RCNT) begin
      txLoad = 1'b1;
      txData = {regs[addr], 8'h00};
    end else if (rxValid && !csNS && state == adc_cmd_pkg::ST_RDATA
                 && remain != 4'h0) begin
      txLoad = 1'b1;
      txData = {regs[addr + 4'h1], 8'h00};
    end else if (opcAccept && op7(rxByte, `OPC7_FETCH)) begin
      txLoad = 1'b1;
      txData = lastResult;
    end else if (convDone && autoNext) begin
      txLoad = 1'b1;
      txData = convResult;
    end
  end

  // Latest conversion result
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)       lastResult <= 16'h0000;
    else if (convDone) lastResult <= convResult;
  end

  // Auto-load mode; change applies at the next ready
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      autoLoad  <= 1'b1;
      pendValid <= 1'b0;
      pendMode  <= 1'b0;
    end else begin
      if (convDone && pendValid) begin
        autoLoad  <= pendMode;
        pendValid <= 1'b0;
      end
      if (rstHit) begin
        autoLoad  <= 1'b1;
        pendValid <= 1'b0;
      end else if (opcAccept && op7(rxByte, `OPC7_AUTO)) begin
        pendValid <= 1'b1;
        pendMode  <= 1'b1;
      end else if (opcAccept && op7(rxByte, `OPC7_HALT)) begin
        pendValid <= 1'b1;
        pendMode  <= 1'b0;
      end
    end
  end

  // Ready low on each result, high once reading starts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resultReadyN <= 1'b1;
      doutEn       <= 1'b0;
    end else begin
      doutEn <= !csNS;
      if (convDone)                   resultReadyN <= 1'b0;
      else if (sclkRise || regsHeld)  resultReadyN <= 1'b1;
    end
  end

  // ----------------------------------------
  // Power, sync and reset hold
  // ----------------------------------------

  // Sleep after the running conversion; wake on 8th edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleepMode <= 1'b0;
      sleepPend <= 1'b0;
    end else begin
      if (opcAccept && op7(rxByte, `OPC7_SLEEP)) sleepPend <= 1'b1;
      if (convDone && sleepPend) begin
        sleepMode <= 1'b1;
        sleepPend <= 1'b0;
      end
      if (rise8 && !csNS && state == adc_cmd_pkg::ST_OPC
          && holdCnt == 16'h0000 && rxPartial == 7'h00) begin
        sleepMode <= 1'b0;
        sleepPend <= 1'b0;
      end
    end
  end

  // Reference follows its own register bits only
  assign refOn = (regs[`REG_REF][`REF_MSB:`REF_LSB] != 2'h0);

  // Reset hold counter and filter controls
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt     <= 16'h0000;
      regsHeld    <= 1'b0;
      filterReset <= 1'b0;
      convRestart <= 1'b0;
    end else begin
      convRestart <= syncHit;
      regsHeld    <= rstHit || holdCnt > 16'h0001;
      filterReset <= syncHit || rstHit || holdCnt > 16'h0001;
      if (rstHit)                    holdCnt <= 16'(RST_HOLD_CYC);
      else if (holdCnt != 16'h0000)  holdCnt <= holdCnt - 16'h0001;
    end
  end

  // ----------------------------------------
  // Register file and calibration
  // ----------------------------------------

  // Reset values while held; else writes, then trims
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= rstVal(4'(i));
    end else if (rstHit || regsHeld) begin
      for (int i = 0; i < 16; i++) regs[i] <= rstVal(4'(i));
    end else begin
      if (rxValid && !csNS && state == adc_cmd_pkg::ST_WDATA)
        regs[addr] <= rxByte;
      if (calDone && calKind == adc_cmd_pkg::CAL_EXT_SPAN) begin
        regs[`REG_GAIN0]        <= calCoef[7:0];
        regs[`REG_GAIN0 + 4'h1] <= calCoef[15:8];
        regs[`REG_GAIN0 + 4'h2] <= calCoef[23:16];
      end else if (calDone && calKind != adc_cmd_pkg::CAL_NONE) begin
        regs[`REG_OFS0]         <= calCoef[7:0];
        regs[`REG_OFS0 + 4'h1]  <= calCoef[15:8];
        regs[`REG_OFS0 + 4'h2]  <= calCoef[23:16];
      end
    end
  end

  // Calibration start and kind
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      calStart <= 1'b0;
      calKind  <= adc_cmd_pkg::CAL_NONE;
    end else begin
      calStart <= 1'b0;
      if (opcAccept && rxByte == `OPC_EXT_ZERO) begin
        calStart <= 1'b1;
        calKind  <= adc_cmd_pkg::CAL_EXT_ZERO;
      end else if (opcAccept && rxByte == `OPC_EXT_SPAN) begin
        calStart <= 1'b1;
        calKind  <= adc_cmd_pkg::CAL_EXT_SPAN;
      end else if (opcAccept && rxByte == `OPC_INT_ZERO) begin
        calStart <= 1'b1;
        calKind  <= adc_cmd_pkg::CAL_INT_ZERO;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic [15:0] holdRun;

  // Length of the current reset hold
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) holdRun <= 16'h0000;
    else         holdRun <= regsHeld ? holdRun + 16'h0001 : 16'h0000;
  end

  a_wake_on_edge: assert property (
    rise8 && !csNS && state == adc_cmd_pkg::ST_OPC && holdCnt == 16'h0000
    && rxPartial == 7'h00 |=> !sleepMode)
    else $error("wake opcode did not leave sleep");

  a_sleep_after_conv: assert property (
    $rose(sleepMode) |-> $past(convDone))
    else $error("sleep entered before conversion end");

  a_ref_kept: assert property (
    $rose(sleepMode) |-> refOn == $past(refOn))
    else $error("reference changed by sleep");

  a_sync_pair: assert property (
    syncHit |=> convRestart && filterReset)
    else $error("second sync byte did not restart");

  a_reset_values: assert property (
    rstHit |=> ##1 regs[`REG_MUX0] == `RST_MUX0 && regs[`REG_IDAC1] == `RST_IDAC1)
    else $error("reset command left register values");

  a_hold_length: assert property (
    $fell(regsHeld) |-> holdRun == 16'(RST_HOLD_CYC))
    else $error("reset hold has wrong length");

  a_mode_at_ready: assert property (
    autoLoad != $past(autoLoad) && !$past(rstHit) |-> $past(convDone))
    else $error("read mode changed away from ready");

  a_halt_stops: assert property (
    convDone && !autoNext |-> !txLoad || rxValid)
    else $error("result loaded after halt");

  a_fetch_loads: assert property (
    opcAccept && op7(rxByte, `OPC7_FETCH) |-> txLoad && txData == lastResult)
    else $error("fetch did not load result");

  a_read_wrap: assert property (
    rxValid && !csNS && state == adc_cmd_pkg::ST_RDATA && remain != 4'h0
    |-> txData[15:8] == regs[addr + 4'h1])
    else $error("register read address wrong");

  a_read_ignores: assert property (
    rxValid && !csNS && state == adc_cmd_pkg::ST_RDATA |=> !calStart && !convRestart)
    else $error("command decoded during register read");

  a_write_store: assert property (
    rxValid && !csNS && state == adc_cmd_pkg::ST_WDATA && !regsHeld && !calDone
    |=> regs[$past(addr)] == $past(rxByte))
    else $error("written byte not stored");

  a_offset_trim: assert property (
    calDone && calKind == adc_cmd_pkg::CAL_EXT_ZERO && !regsHeld && !rstHit
    |=> {regs[6], regs[5], regs[4]} == $past(calCoef))
    else $error("offset trim not updated");

  a_unknown_ignored: assert property (
    opcAccept && rxByte == `OPC_RESERVED |=> state == adc_cmd_pkg::ST_OPC && !calStart)
    else $error("undefined opcode acted on");

  c_sync_seen:  cover property (syncHit);
  c_rread_wrap: cover property (state == adc_cmd_pkg::ST_RDATA && addr == 4'hf
                                && remain != 4'h0 && rxValid);
  c_reg_store_cmd_done:  cover property (rxValid && state == adc_cmd_pkg::ST_WDATA
                                && remain == 4'h0);
  c_sleep_wake: cover property ($fell(sleepMode));

endmodule : adc_spi_command_decoder

// *** tb/spi_host_model.sv ***
// Host serial controller model, clock idle low, data on rising edge
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout
);
  // Idle: clock stands low, deselected
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b1;
  end
  // Half of the 800 ns link period
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask : half
  // Select, then let the pin synchroniser settle
  task automatic sel();
    @(negedge mclk);
    csN = 1'b0;
    half();
  endtask : sel
  // Deselect realigns the interface; no stale data level
  task automatic desel();
    half();
    csN = 1'b1;
    din = ~din;
  endtask : desel
  // Whole or partial byte, MSB first, both directions
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb = 8);
    for (int i = 7; i > 7 - nb; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      half();
      sclk = 1'b0;
      half();
      rx[i] = dout;
    end
  endtask : xfer
endmodule : spi_host_model

// *** tb/tb.sv ***
// Testbench of the serial command decoder
`timescale 1ns/1ps
module tb;
  localparam int HOLD = 20;
  logic               mclk = 1'b0;
  logic               arst_n = 1'b0;
  logic               sclk, csN, din, dout, doutEn, resultReadyN, sleepMode, refOn;
  logic               filterReset, convRestart, regsHeld, calStart;
  logic               convDone = 1'b0;
  logic               calDone = 1'b0;
  logic [15:0]        convResult = 16'h0000;
  logic [23:0]        calCoef = 24'h000000;
  adc_cmd_pkg::cal_e  calKind;
  logic [7:0]         r;
  logic [7:0]         q[4];
  int                 failures = 0;
  int                 nCompared = 0;
  int                 nCal = 0;
  int                 nRst = 0;
  int                 nHeld = 0;
  int                 nFilt = 0;
  int                 nCyc = 0;
  int                 c0;
  typedef struct { logic [7:0] op; int cal; logic [1:0] kind; } row_s;
  row_s rows[5] = '{'{8'h60, 1, 2'h1}, '{8'h61, 1, 2'h2}, '{8'h62, 1, 2'h3},
                    '{8'hff, 0, 2'h3}, '{8'h30, 0, 2'h3}};

  always #50 mclk = ~mclk;

  spi_host_model host (.mclk(mclk), .sclk(sclk), .csN(csN), .din(din), .dout(dout));

  adc_spi_command_decoder #(.RST_HOLD_CYC(HOLD)) uut (
    .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn), .resultReadyN(resultReadyN), .convDone(convDone),
    .convResult(convResult), .sleepMode(sleepMode), .refOn(refOn),
    .filterReset(filterReset), .convRestart(convRestart), .regsHeld(regsHeld),
    .calStart(calStart), .calKind(calKind), .calDone(calDone), .calCoef(calCoef));

  // Pulse counters and hang limit
  always @(posedge mclk) begin
    nCal  <= nCal + int'(calStart);
    nRst  <= nRst + int'(convRestart);
    nHeld <= nHeld + int'(regsHeld);
    nFilt <= nFilt + int'(filterReset);
    nCyc  <= nCyc + 1;
    if (nCyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("TB: %0d compared, %0d failed", nCompared, failures);
    if (failures == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // One framed command byte
  task automatic cmd(input logic [7:0] b);
    host.sel();
    host.xfer(b, r);
    host.desel();
  endtask : cmd

  // New result from the core, only between readouts
  task automatic conv(input logic [15:0] v);
    @(negedge mclk);
    convResult = v;
    convDone = 1'b1;
    @(negedge mclk);
    convDone = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : conv

  task automatic regRead(input logic [3:0] a, input int n, input logic [7:0] fill);
    host.sel();
    host.xfer({4'h2, a}, r);
    host.xfer(8'(n - 1), r);
    for (int j = 0; j < n; j++) host.xfer(fill, q[j]);
    host.desel();
  endtask : regRead

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
    host.sel();
    host.xfer({4'h4, a}, r);
    host.xfer(8'h01, r);
    host.xfer(d0, r);
    host.xfer(d1, r);
    host.desel();
  endtask : regWrite

  // Main sequence
  initial begin
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk({dout, doutEn, resultReadyN, sleepMode, regsHeld, calStart, calKind}, 24'h20);
    foreach (rows[i]) begin
      c0 = nCal;
      cmd(rows[i].op);
      chk(24'(nCal - c0), 24'(rows[i].cal));
      chk(24'(calKind), 24'(rows[i].kind));
    end
    for (int k = 0; k < 2; k++) begin
      cmd(8'h60 + 8'(k));
      @(negedge mclk);
      calCoef = 24'h123456 + 24'(k);
      calDone = 1'b1;
      @(negedge mclk);
      calDone = 1'b0;
      regRead(4'(4 + 3 * k), 3, 8'hff);
      chk({q[2], q[1], q[0]}, 24'h123456 + 24'(k));
    end
    regWrite(4'he, 8'h11, 8'h22);
    regRead(4'he, 3, 8'h06);
    chk({q[0], q[1], q[2]}, 24'h112201);
    chk(24'(nHeld), 24'h0);
    c0 = nRst;
    host.sel();
    host.xfer(8'h04, r);
    host.xfer(8'h05, r);
    host.desel();
    chk(24'(nRst - c0), 24'h1);
    chk(24'(nFilt), 24'h1);
    conv(16'ha5c3);
    chk(24'(resultReadyN), 24'h0);
    host.sel();
    chk(24'(doutEn), 24'h1);
    host.xfer(8'hff, q[0]);
    chk(24'(resultReadyN), 24'h1);
    host.xfer(8'h12, q[1]);
    host.xfer(8'hff, q[2]);
    host.xfer(8'hff, q[3]);
    host.desel();
    chk({q[0], q[1]}, 24'ha5c3);
    chk({q[2], q[3]}, 24'ha5c3);
    conv(16'h5a3c);
    host.sel();
    host.xfer(8'hff, q[0]);
    host.desel();
    chk(24'(q[0]), 24'h5a);
    host.sel();
    host.xfer(8'h12, r);
    host.xfer(8'hff, q[0]);
    host.xfer(8'hff, q[1]);
    host.desel();
    chk({q[0], q[1]}, 24'h5a3c);
    regWrite(4'h2, 8'h20, 8'h00);
    cmd(8'h02);
    chk(24'(sleepMode), 24'h0);
    conv(16'h0001);
    chk({sleepMode, refOn}, 24'h3);
    cmd(8'h00);
    chk(24'(sleepMode), 24'h0);
    c0 = nCal;
    host.sel();
    host.xfer(8'h40, r, 4);
    host.desel();
    cmd(8'h60);
    chk(24'(nCal - c0), 24'h1);
    cmd(8'h06);
    repeat (HOLD + 10) @(negedge mclk);
    chk(24'(nHeld), 24'(HOLD));
    chk(24'(nFilt), 24'(HOLD + 1));
    regRead(4'h2, 1, 8'hff);
    chk(24'(q[0]), 24'h0);
    // Halt: next result not loaded; auto again: loaded
    cmd(8'h16);
    conv(16'h1234);
    host.sel();
    host.xfer(8'hff, q[0]);
    host.desel();
    chk(24'(q[0]), 24'h0);
    cmd(8'h14);
    conv(16'h5678);
    host.sel();
    host.xfer(8'hff, q[0]);
    host.desel();
    chk(24'(q[0]), 24'h56);
    report_and_stop();
  end
endmodule : tb
